//--- src/rsd_pkg.sv
// rsd_pkg: shared constants of the rtc status and defaults block
`default_nettype none
package rsd_pkg;
	// ==========================================================
	// register indices (byte address = index * 4)
	localparam logic [5:0] IDX_HALT = 6'h01;
	localparam logic [5:0] IDX_CENT = 6'h07;
	localparam logic [5:0] IDX_CAL = 6'h08;
	localparam logic [5:0] IDX_WDOG = 6'h09;
	localparam logic [5:0] IDX_ALM = 6'h0A;
	localparam logic [5:0] IDX_HT = 6'h0C;
	localparam logic [5:0] IDX_FLAGS = 6'h0F;
	localparam logic [5:0] IDX_TCTL = 6'h11;
	localparam logic [5:0] IDX_ACAL = 6'h12;
	localparam logic [5:0] IDX_SQW = 6'h13;
	// ==========================================================
	// field positions
	localparam int BIT_ST = 7;
	localparam int BIT_CB_HI = 7;
	localparam int BIT_CB_LO = 6;
	localparam int BIT_OUT = 7;
	localparam int BIT_FT = 6;
	localparam int BIT_ALARM1_IRQ_ENABLE = 7;
	localparam int BIT_HT = 6;
	localparam int BIT_WDF = 7;
	localparam int BIT_AF1 = 6;
	localparam int BIT_AF2 = 5;
	localparam int BIT_BL = 4;
	localparam int BIT_TF = 3;
	localparam int BIT_OF = 2;
	localparam int BIT_TE = 7;
	localparam int BIT_OSC_FAIL_IRQ_ENABLE = 3;
	localparam int BIT_TRIM = 0;
	// ==========================================================
	// writable masks and cold power-up values
	localparam logic [7:0] MASK_ALM = 8'hF0;
	localparam logic [7:0] MASK_TCTL = 8'hE3;
	localparam logic [7:0] MASK_SQW = 8'hF9;
	localparam logic [7:0] COLD_CAL = 8'h80;
	localparam logic [7:0] COLD_ALM = 8'h40;
	localparam logic [7:0] COLD_TCTL = 8'h03;
	localparam logic [7:0] COLD_SQW = 8'h10;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// ==========================================================
	// bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// timing
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned TRIM_WAIT_MS = 8;
	localparam logic [19:0] TRIM_CYCLES = 20'(TRIM_WAIT_MS * (CLK_HZ / 1000));
	localparam logic [16:0] BATT_INTERVAL_S = 17'd86400;
	localparam logic [16:0] SEC_ONE = 17'h00001;
	localparam logic [19:0] CNT_ONE = 20'h00001;
endpackage : rsd_pkg
`default_nettype wire

//--- src/rsd_if.sv
// rsd_if: signals between the status top and its two helpers
`default_nettype none
interface rsd_if;
	logic power_up;
	logic initial_power;
	logic vcc_good;
	logic sec_tick;
	logic batt_below;
	logic battery_low_flag;
	logic century_turn;
	logic [6:0] year_bin;
	logic cb_wr;
	logic [1:0] cb_wdata;
	logic [1:0] century;
	logic leap_year;
	modport top(output power_up, initial_power, vcc_good, sec_tick, batt_below,
		century_turn, year_bin, cb_wr, cb_wdata, input battery_low_flag, century, leap_year);
	modport mon(input power_up, vcc_good, sec_tick, batt_below, output battery_low_flag);
	modport cen(input power_up, initial_power, century_turn, year_bin, cb_wr, cb_wdata,
		output century, leap_year);
endinterface : rsd_if
`default_nettype wire

//--- src/rsd_batt_mon.sv
// rsd_batt_mon: periodic backup-battery test and low flag
`default_nettype none
module rsd_batt_mon
	import rsd_pkg::*;
#(
	parameter logic [16:0] TEST_INTERVAL_S = BATT_INTERVAL_S
)(
	input wire logic aclk,
	input wire logic aresetn,
	rsd_if.mon bus
);
	logic [16:0] sec_cnt_reg;
	logic [16:0] sec_cnt_next;
	logic bl_reg;
	logic bl_next;
	logic wrap;

	always_comb
	begin
		wrap = bus.sec_tick && (sec_cnt_reg == TEST_INTERVAL_S - SEC_ONE); // [R21]
		sec_cnt_next = sec_cnt_reg;
		if (wrap)
			sec_cnt_next = '0;
		else if (bus.sec_tick)
			sec_cnt_next = sec_cnt_reg + SEC_ONE;
		bl_next = bl_reg;
		// a failing test sets, a passing one clears; none on battery [R1] [R3] [R4]
		if (bus.vcc_good && (bus.power_up || wrap))
			bl_next = bus.batt_below; // [R2]
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sec_cnt_reg <= '0;
			bl_reg <= 1'b0;
		end
		else
		begin
			sec_cnt_reg <= sec_cnt_next;
			bl_reg <= bl_next;
		end
	end

	assign bus.battery_low_flag = bl_reg;
endmodule : rsd_batt_mon
`default_nettype wire

//--- src/rsd_century.sv
// rsd_century: two-bit century counter and leap-year decision
`default_nettype none
module rsd_century
	import rsd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	rsd_if.cen bus
);
	logic [1:0] cb_reg;
	logic [1:0] cb_next;
	logic leap_reg;
	logic leap_next;

	always_comb
	begin
		cb_next = cb_reg;
		if (bus.power_up && bus.initial_power)
			cb_next = '0;
		else if (bus.cb_wr)
			cb_next = bus.cb_wdata;
		else if (bus.century_turn)
			cb_next = cb_reg + 2'h1; // [R5]
		// code zero is the only leap century [R6]
		leap_next = (bus.year_bin[1:0] == 2'h0) && ((bus.year_bin != 7'h00) || (cb_next == 2'h0));
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			cb_reg <= '0;
			leap_reg <= 1'b1;
		end
		else
		begin
			cb_reg <= cb_next;
			leap_reg <= leap_next;
		end
	end

	assign bus.century = cb_reg;
	assign bus.leap_year = leap_reg;
endmodule : rsd_century
`default_nettype wire

//--- src/rsd_top.sv
// rsd_top: rtc status, defaults, output pin and trim load behind AXI4-Lite
//
// Implementation choices: the address map and the AXI4-Lite slave port.
`default_nettype none
// Notes on behaviour
// [R1] test battery at power-up and daily
// [R2] low battery sets flag bit 4
// [R3] flag clears only when a later test passes
// [R4] no battery test while on backup
// [R5] century field counts up at century turn
// [R6] leap years by 4/100/400, code zero leap
// [R7] no irq enabled: pin follows output bit
// [R8] pin is open drain, pulls low only
// [R9] oscillator stop sets fail flag
// [R10] fail flag reads one at first power
// [R11] host restarts oscillator via halt toggle
// [R12] fail irq released by enable or flag
// [R13] fail flag holds until host writes zero
// [R14] host waits four seconds before clearing
// [R15] cold power-up loads listed defaults
// [R16] warm power-up clears test, watchdog, timer
// [R17] trim select loads factory trim, read-only
// [R18] trim select off: calibration plain storage
// [R19] host waits 8 ms for trim load
// [R20] flags register layout, low two bits zero
// [R21] daily interval counted from seconds ticks
module rsd_top
	import rsd_pkg::*;
#(
	parameter logic [16:0] TEST_INTERVAL_S = BATT_INTERVAL_S,
	parameter logic [19:0] TRIM_WAIT_CYCLES = TRIM_CYCLES,
	parameter logic [7:0] FACTORY_TRIM = 8'h00
)(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic power_up_pulse,
	input wire logic initial_power,
	input wire logic vcc_good,
	input wire logic batt_below,
	input wire logic sec_tick,
	input wire logic osc_stopped,
	input wire logic century_turn,
	input wire logic [6:0] year_bin,
	input wire logic watchdog_flag,
	input wire logic alarm1_flag,
	input wire logic alarm2_flag,
	input wire logic timer_flag,
	output logic irq_output_pin_o,
	output logic irq_output_pin_oe,
	output logic oscillator_halt_bit,
	output logic leap_year,
	output logic [1:0] century
);
	// ==========================================================
	// helpers
	rsd_if lnk ();

	assign lnk.power_up = power_up_pulse;
	assign lnk.initial_power = initial_power;
	assign lnk.vcc_good = vcc_good;
	assign lnk.sec_tick = sec_tick;
	assign lnk.batt_below = batt_below;
	assign lnk.century_turn = century_turn;
	assign lnk.year_bin = year_bin;

	rsd_batt_mon #(.TEST_INTERVAL_S(TEST_INTERVAL_S)) u_batt (
		.aclk(aclk),
		.aresetn(aresetn),
		.bus(lnk.mon)
	);

	rsd_century u_cent (
		.aclk(aclk),
		.aresetn(aresetn),
		.bus(lnk.cen)
	);

	// ==========================================================
	// state
	logic halt_reg, halt_next;
	logic [7:0] cal_reg, cal_next;
	logic [7:0] wdog_reg, wdog_next;
	logic [7:0] alm_reg, alm_next;
	logic ht_reg, ht_next;
	logic of_reg, of_next;
	logic [7:0] tctl_reg, tctl_next;
	logic [7:0] acal_reg, acal_next;
	logic [7:0] sqw_reg, sqw_next;
	logic [19:0] trim_cnt_reg, trim_cnt_next;
	logic irq_oe_reg, irq_oe_next;
	logic aw_have_reg, aw_have_next;
	logic w_have_reg, w_have_next;
	logic [5:0] aw_idx_reg, aw_idx_next;
	logic [7:0] wbyte_reg, wbyte_next;
	logic wen_reg, wen_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic arready_reg, arready_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [7:0] rdata_reg, rdata_next;
	logic do_wr;
	logic hit;
	logic rd_hit;
	logic [7:0] rd_val;
	logic [7:0] flags;
	logic cold;
	logic any_en;

	// ==========================================================
	// read side mux
	assign flags = {watchdog_flag, alarm1_flag, alarm2_flag, lnk.battery_low_flag,
		timer_flag, of_reg, 2'h0}; // [R20]

	always_comb
	begin
		rd_hit = 1'b1;
		rd_val = BYTE_ZERO;
		case (s_axi_araddr[7:2])
			IDX_HALT: rd_val[BIT_ST] = halt_reg;
			IDX_CENT: rd_val[BIT_CB_HI:BIT_CB_LO] = lnk.century;
			IDX_CAL: rd_val = cal_reg;
			IDX_WDOG: rd_val = wdog_reg;
			IDX_ALM: rd_val = alm_reg;
			IDX_HT: rd_val[BIT_HT] = ht_reg;
			IDX_FLAGS: rd_val = flags; // reading has no side effect here [R12]
			IDX_TCTL: rd_val = tctl_reg;
			IDX_ACAL: rd_val = acal_reg;
			IDX_SQW: rd_val = sqw_reg;
			default: rd_hit = 1'b0;
		endcase
	end

	// ==========================================================
	// next state
	always_comb
	begin
		halt_next = halt_reg;
		cal_next = cal_reg;
		wdog_next = wdog_reg;
		alm_next = alm_reg;
		ht_next = ht_reg;
		of_next = of_reg;
		tctl_next = tctl_reg;
		acal_next = acal_reg;
		sqw_next = sqw_reg;
		trim_cnt_next = trim_cnt_reg;
		aw_have_next = aw_have_reg;
		w_have_next = w_have_reg;
		aw_idx_next = aw_idx_reg;
		wbyte_next = wbyte_reg;
		wen_next = wen_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		lnk.cb_wr = 1'b0;
		lnk.cb_wdata = wbyte_reg[BIT_CB_HI:BIT_CB_LO];
		hit = 1'b1;
		cold = power_up_pulse && initial_power;
		// address and data may arrive in either order
		if (s_axi_awvalid && awready_reg)
		begin
			aw_have_next = 1'b1;
			aw_idx_next = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && wready_reg)
		begin
			w_have_next = 1'b1;
			wbyte_next = s_axi_wdata[7:0];
			wen_next = s_axi_wstrb[0];
		end
		do_wr = aw_have_reg && w_have_reg && !bvalid_reg;
		if (do_wr)
		begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			case (aw_idx_reg)
				IDX_HALT: if (wen_reg) halt_next = wbyte_reg[BIT_ST];
				IDX_CENT: lnk.cb_wr = wen_reg;
				IDX_CAL: if (wen_reg) cal_next = wbyte_reg;
				IDX_WDOG: if (wen_reg) wdog_next = wbyte_reg;
				IDX_ALM: if (wen_reg) alm_next = wbyte_reg & MASK_ALM;
				IDX_HT: if (wen_reg) ht_next = wbyte_reg[BIT_HT];
				IDX_FLAGS: if (wen_reg && !wbyte_reg[BIT_OF]) of_next = 1'b0; // [R13]
				IDX_TCTL: if (wen_reg) tctl_next = wbyte_reg & MASK_TCTL;
				IDX_ACAL: if (wen_reg && !sqw_reg[BIT_TRIM]) acal_next = wbyte_reg; // [R18]
				IDX_SQW: if (wen_reg) sqw_next = wbyte_reg & MASK_SQW;
				default: hit = 1'b0;
			endcase
			bresp_next = hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (bvalid_reg && s_axi_bready)
			bvalid_next = 1'b0;
		if (s_axi_arvalid && arready_reg)
		begin
			rvalid_next = 1'b1;
			rdata_next = rd_val;
			rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		else if (rvalid_reg && s_axi_rready)
			rvalid_next = 1'b0;
		// factory trim: rising select starts the load delay
		if (!sqw_next[BIT_TRIM])
			trim_cnt_next = '0;
		else if (!sqw_reg[BIT_TRIM])
			trim_cnt_next = TRIM_WAIT_CYCLES; // [R17]
		else if (trim_cnt_reg != '0)
			trim_cnt_next = trim_cnt_reg - CNT_ONE;
		if (trim_cnt_reg == CNT_ONE)
			acal_next = FACTORY_TRIM; // [R17]
		// stop wins over a host clear in the same cycle
		if (osc_stopped || halt_reg)
			of_next = 1'b1; // [R9]
		if (cold)
		begin
			// first power: everything to its cold value [R15] [R10]
			halt_next = 1'b0;
			cal_next = COLD_CAL;
			wdog_next = BYTE_ZERO;
			alm_next = COLD_ALM;
			ht_next = 1'b1;
			of_next = 1'b1;
			tctl_next = COLD_TCTL;
			acal_next = BYTE_ZERO;
			sqw_next = COLD_SQW;
			trim_cnt_next = '0;
		end
		else if (power_up_pulse)
		begin
			cal_next[BIT_FT] = 1'b0; // [R16]
			wdog_next = BYTE_ZERO;
			tctl_next[BIT_TE] = 1'b0;
			ht_next = 1'b1;
		end
		// ready only while nothing is held, so one write is in flight
		awready_next = !aw_have_next && !bvalid_next;
		wready_next = !w_have_next && !bvalid_next;
		arready_next = !rvalid_next;
		// open-drain pin, only ever pulls low [R8]
		any_en = sqw_next[BIT_OSC_FAIL_IRQ_ENABLE] || alm_next[BIT_ALARM1_IRQ_ENABLE] || (wdog_next != BYTE_ZERO);
		if (any_en)
			irq_oe_next = (sqw_next[BIT_OSC_FAIL_IRQ_ENABLE] && of_next) // [R12]
				|| (alm_next[BIT_ALARM1_IRQ_ENABLE] && alarm1_flag)
				|| ((wdog_next != BYTE_ZERO) && watchdog_flag);
		else
			irq_oe_next = !cal_next[BIT_OUT]; // [R7]
	end

	// ==========================================================
	// registers; reset equals a cold power-up
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			halt_reg <= 1'b0;
			cal_reg <= COLD_CAL;
			wdog_reg <= BYTE_ZERO;
			alm_reg <= COLD_ALM;
			ht_reg <= 1'b1;
			of_reg <= 1'b1;
			tctl_reg <= COLD_TCTL;
			acal_reg <= BYTE_ZERO;
			sqw_reg <= COLD_SQW;
			trim_cnt_reg <= '0;
			irq_oe_reg <= 1'b0;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_idx_reg <= '0;
			wbyte_reg <= BYTE_ZERO;
			wen_reg <= 1'b0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= BYTE_ZERO;
		end
		else
		begin
			halt_reg <= halt_next;
			cal_reg <= cal_next;
			wdog_reg <= wdog_next;
			alm_reg <= alm_next;
			ht_reg <= ht_next;
			of_reg <= of_next;
			tctl_reg <= tctl_next;
			acal_reg <= acal_next;
			sqw_reg <= sqw_next;
			trim_cnt_reg <= trim_cnt_next;
			irq_oe_reg <= irq_oe_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_idx_reg <= aw_idx_next;
			wbyte_reg <= wbyte_next;
			wen_reg <= wen_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// ==========================================================
	// outputs
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = {24'h000000, rdata_reg};
	assign irq_output_pin_o = 1'b0;
	assign irq_output_pin_oe = irq_oe_reg;
	assign oscillator_halt_bit = halt_reg;
	assign leap_year = lnk.leap_year;
	assign century = lnk.century;
endmodule : rsd_top
`default_nettype wire

//--- bench/rsd_top_sva.sv
// rsd_top_sva: port-level checks of the rtc status block
`default_nettype none
module rsd_top_sva
	import rsd_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic power_up_pulse,
	input wire logic initial_power,
	input wire logic osc_stopped,
	input wire logic century_turn,
	input wire logic [6:0] year_bin,
	input wire logic watchdog_flag,
	input wire logic alarm1_flag,
	input wire logic alarm2_flag,
	input wire logic timer_flag,
	input wire logic irq_output_pin_o,
	input wire logic irq_output_pin_oe,
	input wire logic oscillator_halt_bit,
	input wire logic leap_year,
	input wire logic [1:0] century
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// properties
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	function automatic logic leap_of(input logic [1:0] c, input logic [6:0] y);
		// year zero of a century is leap only for century code zero
		return (y[1:0] == 2'h0) && (y != 7'h00 || c == 2'h0);
	endfunction : leap_of
	a_pin_low_only: assert property (irq_output_pin_o == 1'b0)
		else $error("irq pin data drives high");
	a_century_step: assert property (
		century_turn && !power_up_pulse |=> century == $past(century) + 2'h1)
		else $error("century did not step by one");
	a_century_cold: assert property (
		power_up_pulse && initial_power |=> century == 2'h0 && !oscillator_halt_bit)
		else $error("cold power-up left century or halt set");
	a_warm_halt_keep: assert property (
		power_up_pulse && !initial_power && s_axi_awready && s_axi_wready
		|=> $stable(oscillator_halt_bit))
		else $error("warm power-up changed halt bit");
	a_leap_calc: assert property (
		$stable(year_bin) && $stable(century) && !century_turn && !power_up_pulse
		|=> !$stable(century) || leap_year == leap_of($past(century), $past(year_bin)))
		else $error("leap year decision wrong");
	a_out_after_cold: assert property (
		power_up_pulse && initial_power |=> ##1 !irq_output_pin_oe)
		else $error("pin pulled low with no source after cold power-up");
	a_flags_layout: assert property (
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == {IDX_FLAGS, 2'h0}
		|-> s_axi_rdata[7] == $past(watchdog_flag) && s_axi_rdata[6] == $past(alarm1_flag)
		&& s_axi_rdata[5] == $past(alarm2_flag) && s_axi_rdata[3] == $past(timer_flag)
		&& s_axi_rdata[1:0] == 2'h0)
		else $error("flags register layout wrong");
	a_osc_fail_seen: assert property (
		$rose(s_axi_rvalid) && $past(s_axi_araddr) == {IDX_FLAGS, 2'h0}
		&& ($past(osc_stopped, 2) || $past(oscillator_halt_bit, 2)) |-> s_axi_rdata[BIT_OF])
		else $error("oscillator stop not flagged");
endmodule : rsd_top_sva
bind rsd_top rsd_top_sva rsd_top_sva_i (.*);
`default_nettype wire

//--- bench/rsd_host.sv
// rsd_host: AXI4-Lite host model reaching the status block registers
`default_nettype none
module rsd_host
(
	input wire logic aclk,
	output logic [7:0] s_axi_awaddr,
	output logic s_axi_awvalid,
	input wire logic s_axi_awready,
	output logic [31:0] s_axi_wdata,
	output logic [3:0] s_axi_wstrb,
	output logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	output logic s_axi_bready,
	output logic [7:0] s_axi_araddr,
	output logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	output logic s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================================================
	// bus cycles
	initial
	begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h00000000;
		// full strobes: registers live in the low byte only
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
	end
	task automatic wr(input logic [5:0] idx, input logic [7:0] d, output logic [1:0] r);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end
		while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
		do @(posedge aclk); while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask : wr
	task automatic rd(input logic [5:0] idx, output logic [7:0] d, output logic [1:0] r);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		d = s_axi_rdata[7:0];
		r = s_axi_rresp;
	endtask : rd
endmodule : rsd_host
`default_nettype wire

//--- bench/rsd_top_bench.sv
// rsd_top_bench: register-level regression of the rtc status block
`default_nettype none
module rsd_top_bench
	import rsd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// arbitrary trim pattern, easy to tell from user data
	localparam logic [7:0] TRIM_VAL = 8'hA5;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr, s_axi_araddr, rv;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, century, rr;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic power_up_pulse = 1'b0, initial_power = 1'b0, vcc_good = 1'b1, batt_below = 1'b0;
	logic sec_tick = 1'b0, osc_stopped = 1'b0, century_turn = 1'b0;
	logic watchdog_flag = 1'b0, alarm1_flag = 1'b0, alarm2_flag = 1'b0, timer_flag = 1'b0;
	logic [6:0] year_bin = 7'h00;
	logic irq_output_pin_o, irq_output_pin_oe, oscillator_halt_bit, leap_year;
	int mismatches = 0;
	int samples_checked = 0;
	logic [5:0] ridx [10] = '{IDX_HALT, IDX_CENT, IDX_CAL, IDX_WDOG, IDX_ALM, IDX_HT, IDX_FLAGS,
		IDX_TCTL, IDX_ACAL, IDX_SQW};
	logic [7:0] rexp [10] = '{8'h00, 8'h00, COLD_CAL, 8'h00, COLD_ALM, 8'h40, 8'h04, COLD_TCTL,
		8'h00, COLD_SQW};
	logic [6:0] yrs [3] = '{7'h00, 7'h04, 7'h02};
	always #4 aclk = ~aclk;
	// short counts keep the daily test and trim load inside the run
	rsd_top #(.TEST_INTERVAL_S(17'h00004), .TRIM_WAIT_CYCLES(20'h00005), .FACTORY_TRIM(TRIM_VAL))
		rsd_top_i (.*);
	rsd_host rsd_host_i (.*);
	// ==========================================================
	// tasks
	task automatic finish_test();
		if (mismatches == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc
	task automatic wr(input logic [5:0] idx, input logic [7:0] d);
		rsd_host_i.wr(idx, d, rr);
	endtask : wr
	task automatic rchk(input logic [5:0] idx, input logic [7:0] exp);
		rsd_host_i.rd(idx, rv, rr);
		chk($sformatf("reg %h", idx), exp, rv);
	endtask : rchk
	task automatic pwr(input logic cold);
		initial_power <= cold;
		power_up_pulse <= 1'b1;
		@(posedge aclk);
		power_up_pulse <= 1'b0;
		initial_power <= 1'b0;
		cyc(2);
	endtask : pwr
	task automatic tick();
		sec_tick <= 1'b1;
		@(posedge aclk);
		sec_tick <= 1'b0;
		@(posedge aclk);
	endtask : tick
	// ==========================================================
	// scenarios
	initial
	begin
		cyc(16);
		aresetn <= 1'b1;
		cyc(2);
		foreach (ridx[i]) rchk(ridx[i], rexp[i]);
		rsd_host_i.rd(6'h02, rv, rr);
		chk("unmapped read", {6'h00, RESP_SLVERR}, {6'h00, rr});
		rsd_host_i.wr(6'h02, 8'hFF, rr);
		chk("unmapped write", {6'h00, RESP_SLVERR}, {6'h00, rr});
		wr(IDX_CAL, 8'hC0);
		wr(IDX_WDOG, 8'h05);
		wr(IDX_TCTL, 8'h83);
		wr(IDX_HT, 8'h00);
		batt_below <= 1'b1;
		vcc_good <= 1'b0;
		pwr(1'b0);
		rchk(IDX_FLAGS, 8'h04);
		rchk(IDX_CAL, 8'h80);
		rchk(IDX_WDOG, 8'h00);
		rchk(IDX_TCTL, 8'h03);
		rchk(IDX_HT, 8'h40);
		vcc_good <= 1'b1;
		pwr(1'b0);
		rchk(IDX_FLAGS, 8'h14);
		batt_below <= 1'b0;
		repeat (3) tick();
		rchk(IDX_FLAGS, 8'h14);
		tick();
		rchk(IDX_FLAGS, 8'h04);
		wr(IDX_FLAGS, 8'h00);
		rchk(IDX_FLAGS, 8'h00);
		osc_stopped <= 1'b1;
		cyc(2);
		osc_stopped <= 1'b0;
		rchk(IDX_FLAGS, 8'h04);
		rchk(IDX_FLAGS, 8'h04);
		wr(IDX_SQW, 8'h18);
		cyc(2);
		chk("pin enable", 8'h01, {7'h00, irq_output_pin_oe});
		rchk(IDX_FLAGS, 8'h04);
		cyc(2);
		chk("pin enable", 8'h01, {7'h00, irq_output_pin_oe});
		// oscillator has to run again before the host may clear the flag
		repeat (4) tick();
		wr(IDX_FLAGS, 8'h00);
		cyc(2);
		chk("pin enable", 8'h00, {7'h00, irq_output_pin_oe});
		wr(IDX_HALT, 8'h80);
		chk("halt", 8'h01, {7'h00, oscillator_halt_bit});
		wr(IDX_HALT, 8'h00);
		cyc(2);
		chk("pin enable", 8'h01, {7'h00, irq_output_pin_oe});
		wr(IDX_SQW, 8'h10);
		cyc(2);
		chk("pin enable", 8'h00, {7'h00, irq_output_pin_oe});
		wr(IDX_CAL, 8'h00);
		cyc(2);
		chk("pin enable", 8'h01, {7'h00, irq_output_pin_oe});
		// an armed alarm enable takes the pin away from the output bit
		wr(IDX_ALM, 8'hC0);
		cyc(2);
		chk("pin enable", 8'h00, {7'h00, irq_output_pin_oe});
		wr(IDX_ALM, 8'h40);
		wr(IDX_CAL, 8'h80);
		cyc(2);
		chk("pin enable", 8'h00, {7'h00, irq_output_pin_oe});
		{watchdog_flag, alarm1_flag, alarm2_flag, timer_flag} <= 4'hF;
		cyc(1);
		rchk(IDX_FLAGS, 8'hEC);
		{watchdog_flag, alarm1_flag, alarm2_flag, timer_flag} <= 4'h0;
		for (int i = 1; i <= 4; i++)
		begin
			century_turn <= 1'b1;
			@(posedge aclk);
			century_turn <= 1'b0;
			cyc(2);
			chk("century", 8'(i % 4), {6'h00, century});
			foreach (yrs[j])
			begin
				year_bin <= yrs[j];
				cyc(2);
				chk("leap", {7'h00, yrs[j][1:0] == 2'h0 && (yrs[j] != 7'h00 || i == 4)},
					{7'h00, leap_year});
			end
		end
		wr(IDX_ACAL, 8'h3C);
		rchk(IDX_ACAL, 8'h3C);
		wr(IDX_SQW, 8'h11);
		cyc(8);
		rchk(IDX_ACAL, TRIM_VAL);
		wr(IDX_ACAL, 8'h55);
		rchk(IDX_ACAL, TRIM_VAL);
		wr(IDX_SQW, 8'h10);
		wr(IDX_ACAL, 8'h55);
		rchk(IDX_ACAL, 8'h55);
		pwr(1'b1);
		rchk(IDX_FLAGS, 8'h04);
		rchk(IDX_ACAL, 8'h00);
		finish_test();
	end
	initial
	begin
		#100_000;
		mismatches++;
		finish_test();
	end
endmodule : rsd_top_bench
`default_nettype wire
